// ===== bench/afe_main_config_registers_tb_top.sv
`timescale 1ns/10ps
module afe_main_config_registers_tb_top
  import afemc_pkg::*;
();
  logic clk, rst_b, pll, cal_done, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire hready, hresp, hung;
  wire [31:0] hrdata;
  wire [12:0] outs;
  wire [1:0] rst_p;
  int errors, checks, seed, i, m0, m1, mask, stat, cal;

  afemc_host i_host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata), .hung_o(hung));

  afemc_regs i_dut (.CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
    .PLL_LOCKED_I(pll), .CAL_DONE_I(cal_done),
    .LINE_SYNC_CLK_SEL_O(outs[12]), .LINE_SYNC_EDGE_O(outs[11]),
    .CRYSTAL_DRIVER_ENABLE_O(outs[10]), .MASTER_MODE_O(outs[9]),
    .REGS_LOCKED_O(outs[8]), .SENSOR_TIMING_GENERATOR_RUN_O(outs[7]),
    .SIF_25_CLK_MODE_O(outs[6]), .PLL_AUTOCAL_EN_O(outs[5]),
    .CAL_ACTIVE_O(outs[4]), .FSM_RESET_O(rst_p[0]),
    .REG_RESET_O(rst_p[1]), .PD_AMP_O(outs[3]), .PD_REF_O(outs[2]),
    .PD_GLOBAL_O(outs[1]), .IRQ_O(outs[0]));

  // ----------------------------------------------------------------
  // clock, hang watch and reporting
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (hung === 1'b1) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // model of the two registers plus status and mask
  // ----------------------------------------------------------------
  task automatic wr(input int idx, input int d);
    logic [31:0] r;
    i_host.xfer(1'b1, 32'(idx * 4), 32'(d), r);
    case (idx)
      0: begin
        if (m0 & 32'h1) begin
          if (((d ^ m0) & 32'h36) != 0) stat |= 32'h4;
          m0 = (m0 & 32'h36) | (d & 32'h1);
        end else m0 = d & 32'h37;
      end
      1: begin
        if (d & 32'h8) begin
          m0 = 32'h20;
          m1 = 32'h40;
          mask = 0;
          cal = 0;
        end else begin
          m1 = d & 32'hC7;
          if (d & 32'h10) cal = 0;
          else if (d & 32'h20) cal = 1;
        end
      end
      3: mask = d & 32'h7;
      default: ;
    endcase
  endtask

  task automatic rd(input int idx);
    logic [31:0] r;
    int e;
    i_host.xfer(1'b0, 32'(idx * 4), 32'h0, r);
    case (idx)
      0: e = m0 | (pll << 7);
      1: e = m1 | (cal << 5);
      2: e = stat;
      3: e = mask;
      default: e = 0;
    endcase
    if (idx == 2) stat = 0;
    chk(r, 32'(e));
    chk({31'h0, hresp}, 32'h0);
  endtask

  // outputs settle one cycle after the write, irq in the same cycle
  task automatic outchk();
    logic [12:0] e;
    repeat (2) @(negedge clk);
    e = {m0[5], m0[4], m0[2], m0[1], m0[0], m0[0], m1[7], m1[6], cal[0],
         m1[2], m1[1], m1[0], (stat & mask) != 0};
    chk({27'h0, outs[12:8]}, {27'h0, e[12:8]});
    chk({29'h0, outs[7:5]}, {29'h0, e[7:5]});
    chk({27'h0, outs[4:0]}, {27'h0, e[4:0]});
  endtask

  task automatic pulse(input logic [1:0] e);
    @(negedge clk);
    chk({30'h0, rst_p}, {30'h0, e});
    @(negedge clk);
    chk({30'h0, rst_p}, 32'h0);
  endtask

  task automatic setp(input logic v);
    @(posedge clk);
    if (pll === 1'b1 && v === 1'b0) stat |= 32'h2;
    pll <= v;
  endtask

  task automatic caldone();
    @(posedge clk);
    cal_done <= 1'b1;
    @(posedge clk);
    cal_done <= 1'b0;
    if (cal) stat |= 32'h1;
    cal = 0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    seed = 86870;
    rst_b = 1'b0;
    pll = 1'b0;
    cal_done = 1'b0;
    m0 = 32'h20;
    m1 = 32'h40;
    mask = 0;
    stat = 0;
    cal = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    outchk();
    for (i = 0; i < 4; i++) rd(i);
    $display("test reset values done");
    for (i = 0; i < 12; i++) begin
      setp(1'($random(seed)));
      wr(0, $random(seed) & ~32'h1);
      outchk();
      rd(0);
      wr(1, $random(seed) & 32'hC7);
      wr(3, $random(seed));
      outchk();
      rd(1);
      rd(3);
    end
    rd(2);
    $display("test random configuration done");
    wr(3, 32'h7);
    wr(0, 32'h1);
    outchk();
    wr(0, 32'h37);
    outchk();
    rd(0);
    wr(1, 32'h87);
    outchk();
    rd(1);
    rd(2);
    outchk();
    wr(0, 32'h0);
    outchk();
    $display("test register lock done");
    wr(1, 32'h20);
    outchk();
    rd(1);
    caldone();
    outchk();
    rd(1);
    rd(2);
    wr(1, 32'h20);
    wr(1, m1 | 32'h10);
    pulse(2'b01);
    outchk();
    rd(1);
    $display("test calibration and machine reset done");
    wr(0, 32'h36);
    wr(1, 32'h87);
    wr(1, 32'h8);
    pulse(2'b11);
    outchk();
    rd(0);
    rd(1);
    rd(3);
    $display("test register reset done");
    wr(4, 32'hFF);
    wr(2, 32'h7);
    rd(4);
    rd(0);
    setp(1'b1);
    setp(1'b0);
    wr(3, 32'h2);
    outchk();
    rd(2);
    outchk();
    $display("test unmapped and pll loss done");
    wr(0, 32'h37);
    wr(3, 32'h7);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    m0 = 32'h20;
    m1 = 32'h40;
    mask = 0;
    stat = 0;
    cal = 0;
    outchk();
    rd(0);
    rd(1);
    rd(3);
    $display("test mid-run reset done");
    summarize();
  end
endmodule

// ===== bench/afemc_host.sv
`timescale 1ns/10ps
module afemc_host (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o,
  output logic hung_o
);
  // ----------------------------------------------------------------
  // single word transfers, one at a time
  // ----------------------------------------------------------------
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h2;
    hwdata_o = 32'h0;
    hung_o = 1'b0;
  end

  // bounded so a stuck slave ends the run instead of hanging it
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready_i !== 1'b1 && n < 64);
    if (hready_i !== 1'b1) hung_o <= 1'b1;
  endtask

  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    // stale data must not look valid outside a write data phase
    hwdata_o <= ~hwdata_o;
    wait_ready();
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    wait_ready();
    r = hrdata_i;
  endtask
endmodule

// ===== logic/afemc_pkg.sv
package afemc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [1:0] AFEMC_IDX_CFG0 = 2'h0;
  localparam logic [1:0] AFEMC_IDX_CFG1 = 2'h1;
  localparam logic [1:0] AFEMC_IDX_STAT = 2'h2;
  localparam logic [1:0] AFEMC_IDX_MASK = 2'h3;
  localparam logic [31:0] AFEMC_ADDR_SPAN = 32'h0000_0010;

  localparam logic [7:0] AFEMC_CFG0_RST = 8'h20;
  localparam logic [7:0] AFEMC_CFG1_RST = 8'h40;
  localparam int AFEMC_INT_W = 3;
  localparam logic [AFEMC_INT_W-1:0] AFEMC_MASK_RST = 3'h0;
  localparam logic [AFEMC_INT_W-1:0] AFEMC_STAT_RST = 3'h0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int AFEMC_B0_PLL = 7;
  localparam int AFEMC_B0_UNUSED_HI = 6;
  localparam int AFEMC_B0_CLKSEL = 5;
  localparam int AFEMC_B0_EDGE = 4;
  localparam int AFEMC_B0_UNUSED_LO = 3;
  localparam int AFEMC_B0_CRYSTAL_SOURCE = 2;
  localparam int AFEMC_B0_MASTER = 1;
  localparam int AFEMC_B0_LOCK = 0;
  localparam int AFEMC_B1_SIF = 7;
  localparam int AFEMC_B1_AUTOCAL = 6;
  localparam int AFEMC_B1_CAL = 5;
  localparam int AFEMC_B1_FSMRST = 4;
  localparam int AFEMC_B1_REGRST = 3;
  localparam int AFEMC_B1_PDAMP = 2;
  localparam int AFEMC_B1_PDREF = 1;
  localparam int AFEMC_B1_PDALL = 0;
  localparam int AFEMC_INT_CAL = 0;
  localparam int AFEMC_INT_PLL = 1;
  localparam int AFEMC_INT_REFUSED = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WRITE = 4'h2,
    ST_RDWAIT = 4'h4,
    ST_RDDATA = 4'h8
  } afemc_st_t;

  typedef struct packed {
    logic clk_ext;
    logic fall;
    logic crystal_source;
    logic master;
    logic lock;
  } afemc_clk_t;

  typedef struct packed {
    logic sif25;
    logic autocal;
    logic pd_amp;
    logic pd_ref;
    logic pd_all;
  } afemc_pwr_t;

  typedef struct packed {
    logic hit;
    logic [1:0] idx;
  } afemc_dec_t;

  typedef struct packed {
    afemc_st_t st;
    afemc_dec_t dec;
    logic hready;
    logic [31:0] rdata;
    afemc_clk_t clk;
    afemc_pwr_t pwr;
    logic pll;
    logic cal;
    logic fsm_rst;
    logic reg_rst;
    logic [AFEMC_INT_W-1:0] stat;
    logic [AFEMC_INT_W-1:0] mask;
    logic irq;
  } afemc_state_t;

  // ----------------------------------------------------------------
  // field packing
  // ----------------------------------------------------------------
  function automatic afemc_clk_t afemc_clk_unpack(input logic [7:0] b);
    afemc_clk_t c;
    c.clk_ext = b[AFEMC_B0_CLKSEL];
    c.fall = b[AFEMC_B0_EDGE];
    c.crystal_source = b[AFEMC_B0_CRYSTAL_SOURCE];
    c.master = b[AFEMC_B0_MASTER];
    c.lock = b[AFEMC_B0_LOCK];
    return c;
  endfunction

  function automatic afemc_pwr_t afemc_pwr_unpack(input logic [7:0] b);
    afemc_pwr_t p;
    p.sif25 = b[AFEMC_B1_SIF];
    p.autocal = b[AFEMC_B1_AUTOCAL];
    p.pd_amp = b[AFEMC_B1_PDAMP];
    p.pd_ref = b[AFEMC_B1_PDREF];
    p.pd_all = b[AFEMC_B1_PDALL];
    return p;
  endfunction

  localparam afemc_clk_t AFEMC_CLK_DEF = afemc_clk_unpack(AFEMC_CFG0_RST);
  localparam afemc_pwr_t AFEMC_PWR_DEF = afemc_pwr_unpack(AFEMC_CFG1_RST);

endpackage

// ===== logic/afemc_regs.sv
`timescale 1ns/10ps
module afemc_regs
  import afemc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  input wire logic PLL_LOCKED_I,
  input wire logic CAL_DONE_I,
  output logic LINE_SYNC_CLK_SEL_O,
  output logic LINE_SYNC_EDGE_O,
  output logic CRYSTAL_DRIVER_ENABLE_O,
  output logic MASTER_MODE_O,
  output logic REGS_LOCKED_O,
  output logic SENSOR_TIMING_GENERATOR_RUN_O,
  output logic SIF_25_CLK_MODE_O,
  output logic PLL_AUTOCAL_EN_O,
  output logic CAL_ACTIVE_O,
  output logic FSM_RESET_O,
  output logic REG_RESET_O,
  output logic PD_AMP_O,
  output logic PD_REF_O,
  output logic PD_GLOBAL_O,
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic afemc_dec_t decode(input logic [31:0] a);
    afemc_dec_t d;
    d.idx = a[3:2];
    if (a >= AFEMC_ADDR_SPAN) begin
      d.hit = 1'b0;
    end else if (a[1:0] != 2'h0) begin
      d.hit = 1'b0;
    end else begin
      d.hit = 1'b1;
    end
    return d;
  endfunction

  localparam afemc_state_t STATE_RST = '{
    st: ST_IDLE,
    dec: '0,
    hready: 1'b1,
    rdata: 32'h0000_0000,
    clk: AFEMC_CLK_DEF,
    pwr: AFEMC_PWR_DEF,
    pll: 1'b0,
    cal: 1'b0,
    fsm_rst: 1'b0,
    reg_rst: 1'b0,
    stat: AFEMC_STAT_RST,
    mask: AFEMC_MASK_RST,
    irq: 1'b0
  };

  afemc_state_t state_ff;
  afemc_state_t nxt_state;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    afemc_clk_t wclk;
    logic [AFEMC_INT_W-1:0] ev;
    logic [AFEMC_INT_W-1:0] clr;
    logic [7:0] rb;
    wclk = afemc_clk_unpack(HWDATA_I[7:0]);
    ev = '0;
    clr = '0;
    rb = 8'h00;
    nxt_state = state_ff;
    nxt_state.fsm_rst = 1'b0;
    nxt_state.reg_rst = 1'b0;
    nxt_state.hready = 1'b1;
    nxt_state.pll = PLL_LOCKED_I;
    if (state_ff.pll && !PLL_LOCKED_I) begin
      ev[AFEMC_INT_PLL] = 1'b1;
    end
    if (state_ff.cal && CAL_DONE_I) begin
      nxt_state.cal = 1'b0;
      ev[AFEMC_INT_CAL] = 1'b1;
    end
    case (state_ff.st)
      ST_WRITE: begin
        if (state_ff.dec.hit && state_ff.dec.idx == AFEMC_IDX_CFG0) begin
          if (state_ff.clk.lock) begin
            // only the lock bit itself stays writeable when locked
            nxt_state.clk.lock = wclk.lock;
            if (wclk[4:1] != state_ff.clk[4:1]) begin
              ev[AFEMC_INT_REFUSED] = 1'b1;
            end
          end else begin
            // pll and unused bits are not part of wclk
            nxt_state.clk = wclk;
          end
        end else if (state_ff.dec.hit &&
                     state_ff.dec.idx == AFEMC_IDX_CFG1) begin
          // lock-exempt: resets and power downs must stay reachable
          nxt_state.pwr = afemc_pwr_unpack(HWDATA_I[7:0]);
          if (HWDATA_I[AFEMC_B1_CAL]) begin
            nxt_state.cal = 1'b1;
          end
          if (HWDATA_I[AFEMC_B1_FSMRST]) begin
            nxt_state.fsm_rst = 1'b1;
            nxt_state.cal = 1'b0;
          end
          if (HWDATA_I[AFEMC_B1_REGRST]) begin
            nxt_state.reg_rst = 1'b1;
            nxt_state.fsm_rst = 1'b1;
            nxt_state.cal = 1'b0;
            nxt_state.clk = AFEMC_CLK_DEF;
            nxt_state.pwr = AFEMC_PWR_DEF;
            nxt_state.mask = AFEMC_MASK_RST;
          end
        end else if (state_ff.dec.hit &&
                     state_ff.dec.idx == AFEMC_IDX_MASK) begin
          nxt_state.mask = HWDATA_I[AFEMC_INT_W-1:0];
        end
      end
      ST_RDWAIT: begin
        // one wait state so a write just before is visible to the read
        if (!state_ff.dec.hit) begin
          rb = 8'h00;
        end else if (state_ff.dec.idx == AFEMC_IDX_CFG0) begin
          rb[AFEMC_B0_PLL] = state_ff.pll;
          rb[AFEMC_B0_CLKSEL] = state_ff.clk.clk_ext;
          rb[AFEMC_B0_EDGE] = state_ff.clk.fall;
          rb[AFEMC_B0_CRYSTAL_SOURCE] = state_ff.clk.crystal_source;
          rb[AFEMC_B0_MASTER] = state_ff.clk.master;
          rb[AFEMC_B0_LOCK] = state_ff.clk.lock;
        end else if (state_ff.dec.idx == AFEMC_IDX_CFG1) begin
          rb[AFEMC_B1_SIF] = state_ff.pwr.sif25;
          rb[AFEMC_B1_AUTOCAL] = state_ff.pwr.autocal;
          rb[AFEMC_B1_CAL] = state_ff.cal;
          rb[AFEMC_B1_FSMRST] = state_ff.fsm_rst;
          rb[AFEMC_B1_REGRST] = state_ff.reg_rst;
          rb[AFEMC_B1_PDAMP] = state_ff.pwr.pd_amp;
          rb[AFEMC_B1_PDREF] = state_ff.pwr.pd_ref;
          rb[AFEMC_B1_PDALL] = state_ff.pwr.pd_all;
        end else if (state_ff.dec.idx == AFEMC_IDX_STAT) begin
          rb[AFEMC_INT_W-1:0] = state_ff.stat;
          clr = state_ff.stat;
        end else begin
          rb[AFEMC_INT_W-1:0] = state_ff.mask;
        end
        nxt_state.rdata = {24'h00_0000, rb};
      end
      default: begin
      end
    endcase
    if (state_ff.st == ST_RDWAIT) begin
      nxt_state.st = ST_RDDATA;
    end else if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
      nxt_state.dec = decode(HADDR_I);
      if (HWRITE_I) begin
        nxt_state.st = ST_WRITE;
      end else begin
        nxt_state.st = ST_RDWAIT;
        nxt_state.hready = 1'b0;
      end
    end else begin
      nxt_state.st = ST_IDLE;
    end
    // a new event beats a read-clear in the same cycle
    nxt_state.stat = (state_ff.stat & ~clr) | ev;
    nxt_state.irq = |(nxt_state.stat & nxt_state.mask);
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HREADYOUT_O = state_ff.hready;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = state_ff.rdata;
  assign LINE_SYNC_CLK_SEL_O = state_ff.clk.clk_ext;
  assign LINE_SYNC_EDGE_O = state_ff.clk.fall;
  assign CRYSTAL_DRIVER_ENABLE_O = state_ff.clk.crystal_source;
  assign MASTER_MODE_O = state_ff.clk.master;
  assign REGS_LOCKED_O = state_ff.clk.lock;
  assign SENSOR_TIMING_GENERATOR_RUN_O = state_ff.clk.lock;
  assign SIF_25_CLK_MODE_O = state_ff.pwr.sif25;
  assign PLL_AUTOCAL_EN_O = state_ff.pwr.autocal;
  assign CAL_ACTIVE_O = state_ff.cal;
  assign FSM_RESET_O = state_ff.fsm_rst;
  assign REG_RESET_O = state_ff.reg_rst;
  assign PD_AMP_O = state_ff.pwr.pd_amp;
  assign PD_REF_O = state_ff.pwr.pd_ref;
  assign PD_GLOBAL_O = state_ff.pwr.pd_all;
  assign IRQ_O = state_ff.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_wr(logic [1:0] i);
    state_ff.st == ST_WRITE && state_ff.dec.hit && state_ff.dec.idx == i;
  endsequence

  sequence s_rd(logic [1:0] i);
    state_ff.st == ST_RDDATA && state_ff.dec.hit && state_ff.dec.idx == i;
  endsequence

  sequence s_wr0_open;
    s_wr(AFEMC_IDX_CFG0) ##0 !state_ff.clk.lock;
  endsequence

  sequence s_wr1_plain;
    s_wr(AFEMC_IDX_CFG1) ##0 !HWDATA_I[AFEMC_B1_REGRST];
  endsequence

  property p_pll_read;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_rd(AFEMC_IDX_CFG0) |-> HRDATA_O[AFEMC_B0_PLL] == $past(state_ff.pll);
  endproperty
  a_pll_read: assert property (p_pll_read)
    else $error("pll lock bit reads wrong");

  property p_clk_sel;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr0_open |=> LINE_SYNC_CLK_SEL_O == $past(HWDATA_I[AFEMC_B0_CLKSEL]);
  endproperty
  a_clk_sel: assert property (p_clk_sel)
    else $error("capture clock select not written");

  property p_edge_sel;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr0_open |=> LINE_SYNC_EDGE_O == $past(HWDATA_I[AFEMC_B0_EDGE]);
  endproperty
  a_edge_sel: assert property (p_edge_sel)
    else $error("capture edge select not written");

  property p_crystal_source;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr0_open |=> CRYSTAL_DRIVER_ENABLE_O == $past(HWDATA_I[AFEMC_B0_CRYSTAL_SOURCE]);
  endproperty
  a_crystal_source: assert property (p_crystal_source)
    else $error("crystal driver enable not written");

  property p_master;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr0_open |=> MASTER_MODE_O == $past(HWDATA_I[AFEMC_B0_MASTER]);
  endproperty
  a_master: assert property (p_master)
    else $error("master mode not written");

  property p_unlock;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr(AFEMC_IDX_CFG0) ##0 !HWDATA_I[AFEMC_B0_LOCK]
      |=> !REGS_LOCKED_O && !SENSOR_TIMING_GENERATOR_RUN_O;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock did not halt timing generator");

  property p_lock;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr(AFEMC_IDX_CFG0) ##0 HWDATA_I[AFEMC_B0_LOCK]
      |=> REGS_LOCKED_O && SENSOR_TIMING_GENERATOR_RUN_O;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock did not run timing generator");

  property p_locked_ignore;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr(AFEMC_IDX_CFG0) ##0 state_ff.clk.lock
      |=> $stable(state_ff.clk[4:1]) &&
          (state_ff.stat[AFEMC_INT_REFUSED] ||
           {$past(HWDATA_I[AFEMC_B0_CLKSEL]),
            $past(HWDATA_I[AFEMC_B0_EDGE]),
            $past(HWDATA_I[AFEMC_B0_CRYSTAL_SOURCE]),
            $past(HWDATA_I[AFEMC_B0_MASTER])} == state_ff.clk[4:1]);
  endproperty
  a_locked_ignore: assert property (p_locked_ignore)
    else $error("locked field changed");

  property p_sif;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr1_plain |=> SIF_25_CLK_MODE_O == $past(HWDATA_I[AFEMC_B1_SIF]);
  endproperty
  a_sif: assert property (p_sif)
    else $error("serial mode not written");

  property p_autocal;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr1_plain |=> PLL_AUTOCAL_EN_O == $past(HWDATA_I[AFEMC_B1_AUTOCAL]);
  endproperty
  a_autocal: assert property (p_autocal)
    else $error("autocal enable not written");

  property p_cal_end;
    @(posedge CLK_I) disable iff (!RST_B_I)
    state_ff.cal && CAL_DONE_I && state_ff.st != ST_WRITE
      |=> !CAL_ACTIVE_O && state_ff.stat[AFEMC_INT_CAL];
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration did not self clear");

  property p_fsm_pulse;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr1_plain ##0 HWDATA_I[AFEMC_B1_FSMRST]
      |=> FSM_RESET_O && !CAL_ACTIVE_O && $stable(state_ff.clk)
          ##1 (!FSM_RESET_O || $past(state_ff.st) == ST_WRITE);
  endproperty
  a_fsm_pulse: assert property (p_fsm_pulse)
    else $error("fsm reset pulse wrong");

  property p_reg_reset;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr(AFEMC_IDX_CFG1) ##0 HWDATA_I[AFEMC_B1_REGRST]
      |=> REG_RESET_O && FSM_RESET_O && state_ff.clk == AFEMC_CLK_DEF &&
          state_ff.pwr == AFEMC_PWR_DEF;
  endproperty
  a_reg_reset: assert property (p_reg_reset)
    else $error("register reset did not restore defaults");

  property p_pd;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_wr1_plain |=> {PD_AMP_O, PD_REF_O, PD_GLOBAL_O} == $past(HWDATA_I[2:0]);
  endproperty
  a_pd: assert property (p_pd)
    else $error("power down bits not written");

  property p_defaults;
    @(posedge CLK_I) disable iff (!RST_B_I)
    !$past(RST_B_I) |-> state_ff.clk == AFEMC_CLK_DEF &&
      state_ff.pwr == AFEMC_PWR_DEF && !CAL_ACTIVE_O && HREADYOUT_O;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("reset values wrong");

  property p_unused;
    @(posedge CLK_I) disable iff (!RST_B_I)
    s_rd(AFEMC_IDX_CFG0) |-> !HRDATA_O[AFEMC_B0_UNUSED_HI] &&
      !HRDATA_O[AFEMC_B0_UNUSED_LO] && HRDATA_O[31:8] == 24'h00_0000;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused bits read nonzero");

endmodule
